// ===== ppfs_pkg.sv
// constants and types shared by the port pin function select block
// Overview of operation
// - reserved bits 15 and 11 (and 7, 3) read as zero and writes to them are dropped.
// - field 14..12 picks pin 19 as port, bus data 19, interrupt 3 in, trace 3 out or link status in.
// - field 10..8 picks pin 18 as port, bus data 18, interrupt 2 in, trace 2 out or bidirectional mdio.
// - the low bit of every mode field comes up as 1 when booting in rom-less 32-bit bus mode.
// - an or-type input selected on several pins reaches the core as the or of those pins.
// - an and-type input selected on several pins reaches the core as the and of those pins.
// - an output function drives the same value on every pin selected for it.
package ppfs_pkg;

   localparam int          PPFS_PINS        = 4;
   localparam int          PPFS_FIELD_W     = 3;
   localparam int          PPFS_FIELD_PITCH = 4;
   localparam int          PPFS_ADDR_W      = 12;
   localparam logic [11:0] PPFS_CTRL_OFFSET = 12'h000;
   localparam logic [15:0] PPFS_CTRL_RESET  = 16'h0000;
   localparam logic [15:0] PPFS_CTRL_MASK   = 16'h7777;
   localparam logic [15:0] PPFS_EXT32_BITS  = 16'h1111;
   // pin 19 carries an input-only ethernet function
   localparam logic [3:0]  PPFS_ETH_DRIVES  = 4'b0111;

   typedef enum logic [2:0]
   {
      FN_PORT  = 3'b000,
      FN_BUS   = 3'b001,
      FN_IRQ   = 3'b011,
      FN_TRACE = 3'b100,
      FN_ETH   = 3'b111
   } ppfs_func_type;

   typedef enum logic [1:0]
   {
      ST_SYNC1 = 2'b00,
      ST_SYNC2 = 2'b01,
      ST_LOAD  = 2'b10,
      ST_RUN   = 2'b11
   } ppfs_state_type;

   // peripheral requests toward one pin
   typedef struct packed
   {
      logic port_out;
      logic port_dir;
      logic bus_out;
      logic bus_oe;
      logic trace_out;
      logic eth_out;
      logic eth_oe;
   } ppfs_drive_type;

   // merged pin values toward the peripherals
   typedef struct packed
   {
      logic port_in;
      logic bus_in;
      logic irq_in;
      logic eth_in;
   } ppfs_sense_type;

endpackage

// ===== ppfs_top.sv
// port pin function multiplexer for pins 16 to 19 with apb control register
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module ppfs_top
   import ppfs_pkg::*;
#(
   parameter int PINS = PPFS_PINS
)
(
   input  wire logic                   pclk,          // apb clock
   input  wire logic                   presetn,       // async reset, active low
   input  wire logic                   psel,          // apb select
   input  wire logic                   penable,       // apb access phase
   input  wire logic                   pwrite,        // apb direction
   input  wire logic [PPFS_ADDR_W-1:0] paddr,         // apb byte address
   input  wire logic [31:0]            pwdata,        // apb write data
   output logic      [31:0]            prdata,        // apb read data
   output logic                        pready,        // apb ready
   output logic                        pslverr,       // apb error
   input  wire logic                   boot_ext32,    // strap: rom-less 32-bit bus boot
   input  wire logic [PINS-1:0]        pin_in,        // pin levels, asynchronous
   output logic      [PINS-1:0]        pin_out,       // pin drive values
   output logic      [PINS-1:0]        pin_oe_n,      // pin enables, low drives
   input  wire ppfs_drive_type [PINS-1:0] drive,      // peripheral requests per pin
   input  wire logic [PINS-1:0]        irq_merge_in,  // and-type value from other pins
   input  wire logic [PINS-1:0]        eth_merge_in,  // or-type value from other pins
   output ppfs_sense_type [PINS-1:0]   sense          // merged values to peripherals
);

   generate
      if (PINS < 1 || PINS > PPFS_PINS)
      begin : g_bad_pins
         $error("ppfs_top: PINS must be 1 to 4");
      end
   endgenerate

   logic [15:0]           ctrl_reg;
   logic [15:0]           ctrl_next;
   ppfs_state_type        state_reg;
   logic [1:0]            strap_sync_reg;
   logic [PINS-1:0]       pin_meta_reg;
   logic [PINS-1:0]       pin_sync_reg;
   logic                  access;
   logic                  addr_hit;
   logic                  write_done;

   assign access     = psel && penable;
   assign addr_hit   = (paddr == PPFS_CTRL_OFFSET);
   assign write_done = access && pready && pwrite && addr_hit;

   // strap capture after release: two sync stages, then load
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_sync_reg <= 2'b00;
      end
      else
      begin
         strap_sync_reg <= {strap_sync_reg[0], boot_ext32};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_SYNC1;
      end
      else
      begin
         case (state_reg)
            ST_SYNC1: state_reg <= ST_SYNC2;
            ST_SYNC2: state_reg <= ST_LOAD;
            ST_LOAD:  state_reg <= ST_RUN;
            ST_RUN:   state_reg <= ST_RUN;
            default:  state_reg <= ST_SYNC1;
         endcase
      end
   end

   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (state_reg == ST_LOAD)
      begin
         if (strap_sync_reg[1])
         begin
            ctrl_next = PPFS_EXT32_BITS;
         end
         else
         begin
            ctrl_next = PPFS_CTRL_RESET;
         end
      end
      else if (write_done)
      begin
         ctrl_next = pwdata[15:0] & PPFS_CTRL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= PPFS_CTRL_RESET;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
      end
   end

   // one wait state; no answer until the strap has been loaded
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= access && !pready && (state_reg == ST_RUN);
         pslverr <= access && !pready && (state_reg == ST_RUN) && !addr_hit;
         if (access && !pready && !pwrite && addr_hit && (state_reg == ST_RUN))
         begin
            prdata <= {16'h0000, ctrl_reg & PPFS_CTRL_MASK};
         end
         else
         begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // pins come from outside the clock domain
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end
      else
      begin
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PINS; g = g + 1)
      begin : g_pin
         ppfs_func_type fn;
         logic          out_next;
         logic          oe_n_next;
         ppfs_sense_type sense_next;

         assign fn = ppfs_func_type'(ctrl_reg[g*PPFS_FIELD_PITCH +: PPFS_FIELD_W]);

         always_comb
         begin
            out_next  = 1'b0;
            oe_n_next = 1'b1;
            case (fn)
               FN_PORT:
               begin
                  out_next  = drive[g].port_out;
                  oe_n_next = !drive[g].port_dir;
               end
               FN_BUS:
               begin
                  out_next  = drive[g].bus_out;
                  oe_n_next = !drive[g].bus_oe;
               end
               FN_IRQ:
               begin
                  out_next  = 1'b0;
                  oe_n_next = 1'b1;
               end
               FN_TRACE:
               begin
                  out_next  = drive[g].trace_out;
                  oe_n_next = 1'b0;
               end
               FN_ETH:
               begin
                  out_next  = drive[g].eth_out;
                  oe_n_next = !(drive[g].eth_oe && PPFS_ETH_DRIVES[g]);
               end
               default:
               begin
                  out_next  = 1'b0;
                  oe_n_next = 1'b1;
               end
            endcase
         end

         always_comb
         begin
            sense_next.port_in = (fn == FN_PORT) && pin_sync_reg[g];
            sense_next.bus_in  = (fn == FN_BUS) && pin_sync_reg[g];
            // unselected pins give the neutral value for the merge
            sense_next.irq_in  = ((fn != FN_IRQ) || pin_sync_reg[g])
                                 && irq_merge_in[g];
            sense_next.eth_in  = ((fn == FN_ETH) && pin_sync_reg[g])
                                 || eth_merge_in[g];
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               pin_out[g]  <= 1'b0;
               pin_oe_n[g] <= 1'b1;
            end
            else
            begin
               pin_out[g]  <= out_next;
               pin_oe_n[g] <= oe_n_next;
            end
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sense[g] <= '{port_in: 1'b0, bus_in: 1'b0, irq_in: 1'b1, eth_in: 1'b0};
            end
            else
            begin
               sense[g] <= sense_next;
            end
         end
      end
   endgenerate

endmodule

// ===== ppfs_monitor.sv
// assertions for the pin function select block
`timescale 1ns/1ps
module ppfs_monitor
   import ppfs_pkg::*;
(
   input wire logic                   pclk,         // clock
   input wire logic                   presetn,      // reset
   input wire logic                   psel,         // apb
   input wire logic                   penable,      // apb
   input wire logic                   pwrite,       // apb
   input wire logic [PPFS_ADDR_W-1:0] paddr,        // apb
   input wire logic [31:0]            pwdata,       // apb
   input wire logic [31:0]            prdata,       // apb
   input wire logic                   pready,       // apb
   input wire logic                   pslverr,      // apb
   input wire logic [3:0]             pin_out,      // pin values
   input wire logic [3:0]             pin_oe_n,     // pin enables
   input wire ppfs_drive_type [3:0]   drive,        // requests
   input wire logic [3:0]             irq_merge_in, // and merge
   input wire logic [3:0]             eth_merge_in, // or merge
   input wire ppfs_sense_type [3:0]   sense         // to peripherals
);
   logic [15:0] sh_reg;
   logic        sv_reg;
   // shadow of the control register, valid once software wrote it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sh_reg <= 16'h0000;
         sv_reg <= 1'b0;
      end
      else if (psel && penable && pready && pwrite && paddr == PPFS_CTRL_OFFSET)
      begin
         sh_reg <= pwdata[15:0] & PPFS_CTRL_MASK;
         sv_reg <= 1'b1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_err_unmapped: assert property (pready |-> pslverr == (paddr != PPFS_CTRL_OFFSET))
      else $error("wrong error flag");
   a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
      else $error("bad ready pulse");
   a_rsvd_zero: assert property (pready && !pwrite |-> (prdata & 32'hffff_8888) == 0)
      else $error("reserved bit set");
   a_read_back: assert property (pready && !pwrite && !pslverr && sv_reg
      |-> prdata == {16'h0000, sh_reg}) else $error("read back wrong");
   for (genvar k = 0; k < 4; k++)
   begin : g_pin
      a_trace_out: assert property ($past(sv_reg) && $past(sh_reg[4*k+:3]) == FN_TRACE
         |-> !pin_oe_n[k] && pin_out[k] == $past(drive[k].trace_out)) else $error("trace");
   end
   a_bad_undriven: assert property ($past(sv_reg) && $past(sh_reg[14:12]) inside
      {3'b010, 3'b101, 3'b110, 3'b111} |-> pin_oe_n[3]) else $error("pin driven");
   a_irq_and: assert property ($past(sv_reg) && $past(sh_reg[10:8]) == FN_IRQ
      && !$past(irq_merge_in[2]) |-> !sense[2].irq_in) else $error("irq merge");
   a_eth_or: assert property ($past(sv_reg) && $past(sh_reg[10:8]) == FN_ETH
      && $past(eth_merge_in[2]) |-> sense[2].eth_in) else $error("eth merge");
endmodule
bind ppfs_top ppfs_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pin_out, .pin_oe_n, .drive, .irq_merge_in,
   .eth_merge_in, .sense);

// ===== ppfs_far.sv
// far side model: peripheral requests and board level on the pins
`timescale 1ns/1ps
module ppfs_far
   import ppfs_pkg::*;
(
   input  wire logic           trace_val, // trace bit to send
   input  wire logic [2:0]     lvl,       // eth, bus and port bits to send
   input  wire logic [3:0]     ext_lvl,   // board level where undriven
   input  wire logic [3:0]     pin_out,   // pin values
   input  wire logic [3:0]     pin_oe_n,  // pin enables
   output logic [3:0]          pin_in,    // resolved pin levels
   output ppfs_drive_type [3:0] drive     // peripheral requests
);
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
         drive[i] = '0;
         drive[i].port_out  = lvl[0];
         drive[i].port_dir  = 1'b1;
         drive[i].bus_out   = lvl[1];
         drive[i].bus_oe    = 1'b1;
         drive[i].eth_out   = lvl[2];
         drive[i].eth_oe    = 1'b1;
         drive[i].trace_out = trace_val;
      end
   end
endmodule

// ===== ppfs_top_bench.sv
// testbench for the pin function select block
`timescale 1ns/1ps
module ppfs_top_bench
   import ppfs_pkg::*;
;
   logic                 pclk, presetn, psel, penable, pwrite, boot_ext32, trace_val, er;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic                 pready, pslverr;
   logic [3:0]           pin_in, pin_out, pin_oe_n, ext_lvl, irq_m, eth_m;
   logic [2:0]           lvl;
   ppfs_drive_type [3:0] drive;
   ppfs_sense_type [3:0] sense;
   int                   errors = 0;
   int                   checks_done = 0;
   ppfs_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .boot_ext32, .pin_in, .pin_out, .pin_oe_n, .drive,
      .irq_merge_in(irq_m), .eth_merge_in(eth_m), .sense);
   ppfs_far i_far (.trace_val, .lvl, .ext_lvl, .pin_out, .pin_oe_n, .pin_in, .drive);
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset(input logic strap, input logic [15:0] exp);
      boot_ext32 <= strap;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      chk({pin_out, pin_oe_n, sense, 6'h00, pready, pslverr}, 32'h0f22_2200);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, {16'h0000, exp});
   endtask
   task automatic t_regs();
      apb(1'b1, 12'h000, 32'hffff_ffff);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_7777);
      apb(1'b1, 12'h004, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk({rd[31:1], er}, 32'h0000_0001);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_7777);
   endtask
   task automatic t_codes();
      logic [2:0] c;
      logic [3:0] src;
      logic       v;
      logic [2:0] e;
      for (int i = 0; i < 16; i++)
      begin
         c = i[3:1];
         v = i[0];
         // the chosen function's source carries v, every other source its inverse
         src = {4{~v}};
         if (c == FN_PORT)
            src[0] = v;
         else if (c == FN_BUS)
            src[1] = v;
         else if (c == FN_ETH)
            src[2] = v;
         else if (c == FN_TRACE)
            src[3] = v;
         lvl <= src[2:0];
         trace_val <= src[3];
         apb(1'b1, 12'h000, {16'h0000, {4{1'b0, c}}});
         repeat (5) @(posedge pclk);
         for (int k = 0; k < 4; k++)
         begin
            if (c inside {FN_PORT, FN_BUS, FN_TRACE} || (c == FN_ETH && k != 3))
            begin
               chk(32'(pin_oe_n[k]), 32'h0000_0000);
               chk(32'(pin_out[k]), 32'(v));
            end
            else
               chk(32'(pin_oe_n[k]), 32'h0000_0001);
            e = {c == FN_PORT && v, c == FN_BUS && v, c == FN_ETH && k != 3 && v};
            chk(32'({sense[k].port_in, sense[k].bus_in, sense[k].eth_in}), 32'(e));
         end
      end
   endtask
   task automatic t_merge();
      for (int i = 0; i < 8; i++)
      begin
         if (i == 0 || i == 4)
            apb(1'b1, 12'h000, (i == 0) ? 32'h0000_0300 : 32'h0000_0700);
         ext_lvl <= {1'b0, i[0], 2'b00};
         lvl <= {i[0], 2'b00};
         irq_m <= {4{i[1]}};
         eth_m <= {4{i[1]}};
         repeat (5) @(posedge pclk);
         chk(32'(i[2] ? sense[2].eth_in : sense[2].irq_in),
            32'(i[2] ? (i[0] | i[1]) : (i[0] & i[1])));
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, boot_ext32, trace_val} = 6'h00;
      {paddr, pwdata, ext_lvl, irq_m, eth_m, lvl} = '0;
      t_reset(1'b1, PPFS_EXT32_BITS);
      t_regs();
      t_codes();
      t_merge();
      t_reset(1'b0, PPFS_CTRL_RESET);
      conclude();
   end
   initial
   begin
      #100000;
      errors++;
      conclude();
   end
endmodule
